/* File: pkg/term_pkg.sv */
// Constants, register map and state codes of the terminal print control.
// Assumes a 100 MHz core clock and a single AHB-Lite slave port.
package term_pkg;

    // ==========================================================
    // Clock and page store timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STORE_BIT_HZ  = 768_000;
    localparam int BIT_DIV_CYC   = CLK_HZ / STORE_BIT_HZ;
    localparam int CHAR_BITS     = 10;
    localparam int STORE_BITS    = 12_800;
    localparam int DISP_CHARS    = 1080;
    localparam int RETRACE_SLOTS = 200;
    localparam int SLOTS         = DISP_CHARS + RETRACE_SLOTS;
    localparam int LINES         = 20;
    localparam int COLS          = 54;
    localparam int SYNC_GAP_NS   = 14_300;
    localparam int SYNC_GAP_CYC  = SYNC_GAP_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Serial lines
    localparam int LINE_BAUD     = 1200;
    localparam int BAUD_CYC_DEF  = CLK_HZ / LINE_BAUD;
    localparam int PRINT_CPS     = 10;
    localparam int PACE_CYC_DEF  = CLK_HZ / PRINT_CPS;
    localparam int FRAME_BITS    = 10;
    localparam int CNT_W         = 24;

    // ==========================================================
    // Character codes
    localparam logic [6:0] CH_NUL   = 7'h00;
    localparam logic [6:0] CH_STX   = 7'h02;
    localparam logic [6:0] CH_ETX   = 7'h03;
    localparam logic [6:0] CH_LF    = 7'h0A;
    localparam logic [6:0] CH_CR    = 7'h0D;
    localparam logic [6:0] CH_SPACE = 7'h20;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_KEY    = 8'h0C;
    localparam logic [7:0] OFF_CURSOR = 8'h10;
    localparam int CTRL_SEG_BIT   = 0;
    localparam int CMD_PRINT_BIT  = 0;
    localparam int CMD_XMIT_BIT   = 1;
    localparam int CMD_CLEAR_BIT  = 2;
    localparam int CUR_LINE_LSB   = 8;
    localparam logic CTRL_SEG_RST = 1'b0;

    // ==========================================================
    // State codes
    typedef enum logic [3:0] {
        M_WRITE = 4'b0001,
        M_PRINT = 4'b0010,
        M_XMIT  = 4'b0100,
        M_AWAIT = 4'b1000
    } mode_t;

    typedef enum logic [4:0] {
        F_STX  = 5'b00001,
        F_DATA = 5'b00010,
        F_CR   = 5'b00100,
        F_LF   = 5'b01000,
        F_ETX  = 5'b10000
    } feed_t;

    typedef enum logic [2:0] {
        T_RUN  = 3'b001,
        T_WAIT = 3'b010,
        T_HOLD = 3'b100
    } sync_t;

endpackage : term_pkg

/* File: hw/terminal_message_print_control.sv */
// Page store, resync timing, print run and host message framing.
// Assumes an AHB-Lite master on the register port and synchronous pins.
//
// What this block does
// - Print accepted only in write mode.
// - Print lamp on, write lamp off.
// - Page printed at ten cps, 20 lines.
// - CR then LF after every printed line.
// - Stored nulls printed as spaces.
// - End-of-text ends print, back to write.
// - Segment select starts at cursor mark.
// - Format characters printed with variable data.
// - Host message opens with generated STX.
// - Characters shifted out least bit first.
// - ETX after message, then await reply.
// - Host serial data at 1200 baud.
// - Reply ETX returns to write mode.
// - Page store holds 12,800 bits.
// - Store shifts at 768,000 bits per second.
// - Key code held, then written serially.
// - Two sync bits, clock stop, recount.
// - Resync at power-up, each page, clear.
// - Clear resets hold, wait; sets start.
// - Regenerated sync pulses 14.3 us apart.
`timescale 1ns/1ps
`default_nettype none

module terminal_message_print_control
    import term_pkg::*;
#(
    parameter int BAUD_CYC = BAUD_CYC_DEF,
    parameter int PACE_CYC = PACE_CYC_DEF,
    parameter int STORE_DIV = BIT_DIV_CYC
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Serial lines
    input  wire logic        i_host_rxd,
    output logic             o_host_txd,
    output logic             o_prn_txd,
    // Indicators and page sync
    output logic             o_write_lamp,
    output logic             o_print_lamp,
    output logic             o_xmit_lamp,
    output logic             o_sync_pulse
);

    // ==========================================================
    // Register bus
    logic             wr_pend_ff;
    logic [7:0]       wr_addr_ff;
    logic [31:0]      hrdata_ff;
    logic             seg_ff;
    logic [7:0]       hold_ff;
    logic             key_pend_ff;
    logic [4:0]       cur_line_ff;
    logic [5:0]       cur_col_ff;
    mode_t            mode_ff;
    mode_t            nxt_mode;
    logic             sync_ok_ff;
    logic             erase_ff;

    wire ahb_go   = i_hsel & i_htrans[1] & i_hready;
    wire word_acc = (i_hsize == 3'b010);
    wire wr_ctrl  = wr_pend_ff & (wr_addr_ff == OFF_CTRL);
    wire wr_cmd   = wr_pend_ff & (wr_addr_ff == OFF_CMD);
    wire wr_key   = wr_pend_ff & (wr_addr_ff == OFF_KEY);
    wire wr_cur   = wr_pend_ff & (wr_addr_ff == OFF_CURSOR);

    wire in_write = (mode_ff == M_WRITE);
    wire in_print = (mode_ff == M_PRINT);
    wire in_xmit  = (mode_ff == M_XMIT);
    wire in_await = (mode_ff == M_AWAIT);

    wire [31:0] status_word = {26'h0000000, key_pend_ff, sync_ok_ff,
                               in_await, in_xmit, in_print, in_write};
    wire [31:0] cursor_word = {19'h00000, cur_line_ff, 2'b00, cur_col_ff};
    wire [7:0]  rd_addr     = i_haddr[7:0];
    wire [31:0] rd_word =
        (rd_addr == OFF_CTRL)   ? {31'h00000000, seg_ff} :
        (rd_addr == OFF_STATUS) ? status_word :
        (rd_addr == OFF_KEY)    ? {24'h000000, hold_ff} :
        (rd_addr == OFF_CURSOR) ? cursor_word : 32'h00000000;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h00000000;
        end else begin
            wr_pend_ff <= ahb_go & i_hwrite & word_acc;
            if (ahb_go) begin
                wr_addr_ff <= i_haddr[7:0];
            end
            if (ahb_go & ~i_hwrite) begin
                hrdata_ff <= rd_word;
            end
        end
    end

    assign o_hrdata    = hrdata_ff;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // Operator commands, taken from the command register.
    wire cmd_ok   = wr_cmd & in_write & ~erase_ff;
    wire clr_go   = wr_cmd & in_write & i_hwdata[CMD_CLEAR_BIT];
    wire print_go = cmd_ok & ~clr_go & i_hwdata[CMD_PRINT_BIT];
    wire xmit_go  = cmd_ok & ~clr_go & ~print_go & i_hwdata[CMD_XMIT_BIT];

    // ==========================================================
    // Page store timing and resync
    logic [7:0]  bdiv_ff;
    logic [3:0]  bitc_ff;
    logic [10:0] slot_ff;
    logic [10:0] gap_ff;
    logic        start_ff;
    logic        sync_pulse_ff;
    sync_t       tstate_ff;

    wire clk_run  = (tstate_ff != T_HOLD);
    wire bit_en   = clk_run & (bdiv_ff == 8'(STORE_DIV - 1));
    wire char_en  = bit_en & (bitc_ff == 4'(CHAR_BITS - 1));
    wire page_end = char_en & (slot_ff == 11'(SLOTS - 1));
    wire gap_done = (tstate_ff == T_HOLD) & (gap_ff == 11'h000);
    wire restart  = gap_done | clr_go;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bdiv_ff <= 8'h00;
            bitc_ff <= 4'h0;
            slot_ff <= 11'h000;
        end else if (restart) begin
            bdiv_ff <= 8'h00;
            bitc_ff <= 4'h0;
            slot_ff <= 11'h000;
        end else if (clk_run) begin
            bdiv_ff <= bit_en ? 8'h00 : bdiv_ff + 8'h01;
            if (bit_en) begin
                bitc_ff <= char_en ? 4'h0 : bitc_ff + 4'h1;
            end
            if (char_en) begin
                slot_ff <= page_end ? 11'h000 : slot_ff + 11'h001;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tstate_ff     <= T_RUN;
            gap_ff        <= 11'h000;
            start_ff      <= 1'b1;
            sync_ok_ff    <= 1'b0;
            erase_ff      <= 1'b1;
            sync_pulse_ff <= 1'b0;
        end else if (clr_go) begin
            tstate_ff     <= T_RUN;
            start_ff      <= 1'b1;
            sync_ok_ff    <= 1'b0;
            erase_ff      <= 1'b1;
            sync_pulse_ff <= 1'b0;
        end else begin
            sync_pulse_ff <= (tstate_ff == T_WAIT) | gap_done;
            unique case (tstate_ff)
                T_RUN: begin
                    if (page_end) begin
                        tstate_ff <= T_WAIT;
                        erase_ff  <= 1'b0;
                    end
                end
                T_WAIT: begin
                    tstate_ff <= T_HOLD;
                    gap_ff    <= 11'(SYNC_GAP_CYC - 1);
                end
                T_HOLD: begin
                    if (gap_ff == 11'h000) begin
                        tstate_ff  <= T_RUN;
                        sync_ok_ff <= 1'b1;
                        start_ff   <= 1'b0;
                    end else begin
                        gap_ff <= gap_ff - 11'h001;
                    end
                end
            endcase
        end
    end

    assign o_sync_pulse = sync_pulse_ff;

    // ==========================================================
    // Page store and keyboard entry
    logic [9:0]  store_mem [SLOTS];
    logic [10:0] idx_ff;
    logic [10:0] rx_ptr_ff;
    logic [6:0]  rx_ch;
    logic        rx_store;

    wire [10:0] cur_idx   = 11'(cur_line_ff) * 11'(COLS) + 11'(cur_col_ff);
    wire        key_store = key_pend_ff & char_en & ~erase_ff &
                            (slot_ff == cur_idx);
    wire        erase_we  = erase_ff & char_en;
    wire        mem_we    = erase_we | key_store | rx_store;
    wire [10:0] mem_wa    = erase_we  ? slot_ff :
                            key_store ? cur_idx : rx_ptr_ff;
    wire [9:0]  mem_wd    = erase_we  ? 10'h000 :
                            key_store ? {2'b00, hold_ff} : {3'b000, rx_ch};
    wire [9:0]  rd_slot   = store_mem[idx_ff];
    wire [6:0]  rd_ch     = rd_slot[6:0];

    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            store_mem[mem_wa] <= mem_wd;
        end
    end

    wire col_last  = (cur_col_ff == 6'(COLS - 1));
    wire line_last = (cur_line_ff == 5'(LINES - 1));

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seg_ff      <= CTRL_SEG_RST;
            hold_ff     <= 8'h00;
            key_pend_ff <= 1'b0;
            cur_line_ff <= 5'h00;
            cur_col_ff  <= 6'h00;
        end else begin
            if (wr_ctrl) begin
                seg_ff <= i_hwdata[CTRL_SEG_BIT];
            end
            if (wr_key & in_write & ~key_pend_ff) begin
                hold_ff     <= i_hwdata[7:0];
                key_pend_ff <= 1'b1;
            end else if (key_store | clr_go) begin
                key_pend_ff <= 1'b0;
            end
            if (clr_go) begin
                cur_line_ff <= 5'h00;
                cur_col_ff  <= 6'h00;
            end else if (wr_cur) begin
                cur_line_ff <= i_hwdata[CUR_LINE_LSB +: 5];
                cur_col_ff  <= i_hwdata[5:0];
            end else if (key_store) begin
                cur_col_ff <= col_last ? 6'h00 : cur_col_ff + 6'h01;
                if (col_last) begin
                    cur_line_ff <= line_last ? 5'h00 : cur_line_ff + 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // Character feeder for printer and host
    feed_t            fd_ff;
    feed_t            nxt_fd;
    logic [5:0]       col_ff;
    logic [3:0]       tx_left_ff;
    logic [CNT_W-1:0] pace_ff;
    logic             send;
    logic [6:0]       send_ch;
    logic             idx_inc;
    logic             end_print;
    logic             end_xmit;
    logic             rx_end;

    wire tx_idle  = (tx_left_ff == 4'h0);
    wire pace_ok  = ~in_print | (pace_ff == '0);
    wire feed_go  = tx_idle & pace_ok & (in_print | in_xmit);
    wire text_end = (rd_ch == CH_ETX) | (idx_ff >= 11'(DISP_CHARS));

    always_comb begin
        nxt_fd    = fd_ff;
        send      = 1'b0;
        send_ch   = CH_NUL;
        idx_inc   = 1'b0;
        end_print = 1'b0;
        end_xmit  = 1'b0;
        if (feed_go) begin
            unique case (fd_ff)
                F_STX: begin
                    send    = 1'b1;
                    send_ch = CH_STX;
                    nxt_fd  = F_DATA;
                end
                F_DATA: begin
                    if (text_end) begin
                        end_print = in_print;
                        nxt_fd    = in_print ? F_DATA : F_ETX;
                    end else begin
                        send    = 1'b1;
                        idx_inc = 1'b1;
                        send_ch = (in_print & (rd_ch == CH_NUL)) ?
                                  CH_SPACE : rd_ch;
                        if (in_print & (col_ff == 6'(COLS - 1))) begin
                            nxt_fd = F_CR;
                        end
                    end
                end
                F_CR: begin
                    send    = 1'b1;
                    send_ch = CH_CR;
                    nxt_fd  = F_LF;
                end
                F_LF: begin
                    send    = 1'b1;
                    send_ch = CH_LF;
                    nxt_fd  = F_DATA;
                end
                F_ETX: begin
                    send     = 1'b1;
                    send_ch  = CH_ETX;
                    end_xmit = 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        nxt_mode = mode_ff;
        if (print_go) begin
            nxt_mode = M_PRINT;
        end else if (xmit_go) begin
            nxt_mode = M_XMIT;
        end else if (end_print | rx_end) begin
            nxt_mode = M_WRITE;
        end else if (end_xmit) begin
            nxt_mode = M_AWAIT;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_ff <= M_WRITE;
            fd_ff   <= F_DATA;
            idx_ff  <= 11'h000;
            col_ff  <= 6'h00;
        end else begin
            mode_ff <= nxt_mode;
            fd_ff   <= nxt_fd;
            if (print_go | xmit_go) begin
                idx_ff <= seg_ff ? cur_idx : 11'h000;
                col_ff <= seg_ff ? cur_col_ff : 6'h00;
                fd_ff  <= print_go ? F_DATA : F_STX;
            end else if (idx_inc) begin
                idx_ff <= idx_ff + 11'h001;
                col_ff <= (col_ff == 6'(COLS - 1)) ? 6'h00 : col_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_write_lamp <= 1'b1;
            o_print_lamp <= 1'b0;
            o_xmit_lamp  <= 1'b0;
        end else begin
            o_write_lamp <= (nxt_mode == M_WRITE);
            o_print_lamp <= (nxt_mode == M_PRINT);
            o_xmit_lamp  <= (nxt_mode == M_XMIT) | (nxt_mode == M_AWAIT);
        end
    end

    // ==========================================================
    // Serial transmitter shared by printer and host line
    logic [9:0]       tx_sh_ff;
    logic [CNT_W-1:0] tx_baud_ff;
    logic             tx_prn_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_sh_ff   <= 10'h3FF;
            tx_left_ff <= 4'h0;
            tx_baud_ff <= '0;
            tx_prn_ff  <= 1'b0;
            pace_ff    <= '0;
            o_host_txd <= 1'b1;
            o_prn_txd  <= 1'b1;
        end else begin
            if (send & in_print) begin
                pace_ff <= CNT_W'(PACE_CYC - 1);
            end else if (pace_ff != '0) begin
                pace_ff <= pace_ff - 1'b1;
            end
            if (send) begin
                tx_sh_ff   <= {1'b1, 1'b0, send_ch, 1'b0};
                tx_left_ff <= 4'(FRAME_BITS);
                tx_baud_ff <= CNT_W'(BAUD_CYC - 1);
                tx_prn_ff  <= in_print;
            end else if (~tx_idle) begin
                if (tx_baud_ff == '0) begin
                    tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
                    tx_left_ff <= tx_left_ff - 4'h1;
                    tx_baud_ff <= CNT_W'(BAUD_CYC - 1);
                end else begin
                    tx_baud_ff <= tx_baud_ff - 1'b1;
                end
            end
            o_host_txd <= (tx_idle | tx_prn_ff) ? 1'b1 : tx_sh_ff[0];
            o_prn_txd  <= (tx_idle | ~tx_prn_ff) ? 1'b1 : tx_sh_ff[0];
        end
    end

    // ==========================================================
    // Host reply receiver
    logic             rx_busy_ff;
    logic [CNT_W-1:0] rx_baud_ff;
    logic [3:0]       rx_bits_ff;
    logic [7:0]       rx_sh_ff;
    logic             rx_open_ff;

    wire rx_tick = rx_busy_ff & (rx_baud_ff == '0);
    wire rx_done = rx_tick & (rx_bits_ff == 4'(FRAME_BITS - 1));
    wire rx_room = (rx_ptr_ff < 11'(DISP_CHARS));
    assign rx_ch = rx_sh_ff[6:0];
    wire rx_take = rx_done & in_await;
    wire rx_stx  = rx_take & (rx_ch == CH_STX);
    assign rx_end   = rx_take & rx_open_ff & (rx_ch == CH_ETX);
    assign rx_store = rx_take & rx_open_ff & rx_room &
                      (rx_ch != CH_ETX) & (rx_ch != CH_STX);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_busy_ff <= 1'b0;
            rx_baud_ff <= '0;
            rx_bits_ff <= 4'h0;
            rx_sh_ff   <= 8'h00;
        end else if (~rx_busy_ff) begin
            if (~i_host_rxd) begin
                rx_busy_ff <= 1'b1;
                rx_baud_ff <= CNT_W'(BAUD_CYC / 2);
                rx_bits_ff <= 4'h0;
            end
        end else if (rx_tick) begin
            rx_baud_ff <= CNT_W'(BAUD_CYC - 1);
            rx_bits_ff <= rx_bits_ff + 4'h1;
            if ((rx_bits_ff == 4'h0) & i_host_rxd) begin
                rx_busy_ff <= 1'b0;
            end else if (rx_done) begin
                rx_busy_ff <= 1'b0;
            end else if (rx_bits_ff != 4'h0) begin
                rx_sh_ff <= {i_host_rxd, rx_sh_ff[7:1]};
            end
        end else begin
            rx_baud_ff <= rx_baud_ff - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_open_ff <= 1'b0;
            rx_ptr_ff  <= 11'h000;
        end else if (end_xmit) begin
            rx_open_ff <= 1'b0;
            rx_ptr_ff  <= idx_ff + 11'h001;
        end else begin
            if (rx_stx) begin
                rx_open_ff <= 1'b1;
            end else if (rx_end) begin
                rx_open_ff <= 1'b0;
            end
            if (rx_store) begin
                rx_ptr_ff <= rx_ptr_ff + 11'h001;
            end
        end
    end

endmodule : terminal_message_print_control

`default_nettype wire

/* File: sim/term_print_chk.sv */
// Concurrent checks on the ports of the print control block.
// Assumes it is bound into the print control module with the same BAUD_CYC.
`timescale 1ns/1ps
`default_nettype none
module term_print_chk #(parameter int BAUD_CYC = 16) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_host_txd,
    input wire logic o_prn_txd,
    input wire logic o_write_lamp,
    input wire logic o_print_lamp,
    input wire logic o_xmit_lamp,
    input wire logic o_sync_pulse
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // =========================================================
    // Idle and gap counters
    int prn_ff;
    int host_ff;
    int gap_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prn_ff  <= 0;
            host_ff <= 0;
            gap_ff  <= 0;
        end else begin
            prn_ff  <= o_print_lamp ? 0 : prn_ff + 1;
            host_ff <= o_xmit_lamp ? 0 : host_ff + 1;
            gap_ff  <= o_sync_pulse ? 0 : gap_ff + 1;
        end
    end
    sequence write_off;
        $fell(o_write_lamp);
    endsequence
    // =========================================================
    // Assertions
    bus_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready or not okay");
    lamp_onehot_a: assert property ($onehot({o_write_lamp, o_print_lamp,
        o_xmit_lamp})) else $error("mode lamps not one hot");
    prn_entry_a: assert property ($rose(o_print_lamp) |-> write_off)
        else $error("print entered outside write mode");
    xmit_entry_a: assert property ($rose(o_xmit_lamp) |-> write_off)
        else $error("transmit entered outside write mode");
    prn_exit_a: assert property ($fell(o_print_lamp) |-> $rose(o_write_lamp))
        else $error("print ended without write mode");
    reply_exit_a: assert property ($fell(o_xmit_lamp) |-> $rose(o_write_lamp))
        else $error("reply ended without write mode");
    prn_idle_a: assert property (prn_ff > 40 * BAUD_CYC |-> o_prn_txd)
        else $error("printer line active outside print");
    host_idle_a: assert property (host_ff > 20 * BAUD_CYC |-> o_host_txd)
        else $error("host line active outside transmit");
    sync_gap_a: assert property (o_sync_pulse |-> gap_ff >= 1429)
        else $error("sync pulses too close");
    sync_single_a: assert property (o_sync_pulse |=> !o_sync_pulse)
        else $error("sync pulse longer than one cycle");
endmodule : term_print_chk
bind terminal_message_print_control term_print_chk #(.BAUD_CYC(BAUD_CYC))
    chk_u (.i_core_clk, .i_rst_b, .o_hreadyout, .o_hresp, .o_host_txd,
    .o_prn_txd, .o_write_lamp, .o_print_lamp, .o_xmit_lamp, .o_sync_pulse);
`default_nettype wire

/* File: sim/host_line_model.sv */
// Host side of the serial line: sends framed replies.
// Assumes the bench clock and the block's bit time in cycles.
`timescale 1ns/1ps
`default_nettype none
module host_line_model import term_pkg::*; #(parameter int BAUD_CYC = 16) (
    input wire logic i_core_clk,
    output var logic o_rxd
);
    initial o_rxd = 1'b1;
    task automatic send_char(input logic [6:0] c);
        logic [9:0] f;
        f = {1'b1, 1'b0, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= f[i];
            repeat (BAUD_CYC) @(posedge i_core_clk);
        end
    endtask : send_char
    task automatic send_reply(input logic [6:0] c);
        send_char(CH_STX);
        send_char(c);
        send_char(CH_ETX);
    endtask : send_reply
endmodule : host_line_model
`default_nettype wire

/* File: sim/terminal_message_print_control_tb_top.sv */
// Bench top: clock, reset, bus tasks and scenarios.
// Assumes the checker is bound in and the host model is compiled.
`timescale 1ns/1ps
`default_nettype none
module terminal_message_print_control_tb_top;
    import term_pkg::*;
    logic        clk, rst_b, hsel, hwrite, rdy, resp, rxd, htxd, ptxd;
    logic        wl, pl, xl, sp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int          miscompares, num_checks;
    terminal_message_print_control #(.BAUD_CYC(16), .PACE_CYC(400),
        .STORE_DIV(2)) dut_u (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
        .o_hreadyout(rdy), .o_hresp(resp), .i_host_rxd(rxd),
        .o_host_txd(htxd), .o_prn_txd(ptxd), .o_write_lamp(wl),
        .o_print_lamp(pl), .o_xmit_lamp(xl), .o_sync_pulse(sp));
    host_line_model #(.BAUD_CYC(16)) host_u (.i_core_clk(clk), .o_rxd(rxd));
    // =========================================================
    // Compare, bus and closing tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(hrdata, e);
    endtask : rdc
    task automatic wait_st(input logic [31:0] e);
        do bus(1'b0, OFF_STATUS, 32'h0); while (hrdata !== e);
    endtask : wait_st
    // Samples one serial frame mid-bit and checks data and stop bit.
    task automatic rx_char(input logic prn, input logic [7:0] e);
        logic [7:0] c;
        c = 8'h00;
        while ((prn ? ptxd : htxd) !== 1'b0) @(posedge clk);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk);
            c = {(prn ? ptxd : htxd), c[7:1]};
        end
        repeat (16) @(posedge clk);
        chk({23'h000000, (prn ? ptxd : htxd), c}, {23'h000000, 1'b1, e});
    endtask : rx_char
    task automatic lamps();
        repeat (3) @(posedge clk);
        chk({26'h0, wl, pl, xl, htxd, ptxd, sp}, 32'h26);
    endtask : lamps
    task automatic test_done();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // =========================================================
    // Scenarios
    task automatic t_regs();
        lamps();
        rdc(OFF_STATUS, 32'h1);
        bus(1'b1, OFF_CTRL, 32'h1);
        rdc(OFF_CTRL, 32'h1);
        bus(1'b1, OFF_CURSOR, 32'h1335);
        rdc(OFF_CURSOR, 32'h1335);
        bus(1'b1, 8'h14, 32'hFFFFFFFF);
        rdc(8'h14, 32'h0);
        rdc(OFF_CMD, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0);
        rdc(OFF_CTRL, 32'h0);
    endtask : t_regs
    task automatic t_refuse();
        bus(1'b1, OFF_CMD, 32'h1);
        lamps();
        bus(1'b1, OFF_CMD, 32'h2);
        lamps();
        bus(1'b1, OFF_CURSOR, 32'h0);
        bus(1'b1, OFF_KEY, 32'h41);
        rdc(OFF_KEY, 32'h41);
    endtask : t_refuse
    task automatic t_reply();
        host_u.send_reply(7'h41);
        lamps();
        rdc(OFF_STATUS, 32'h21);
    endtask : t_reply
    task automatic t_run();
        wait_st(32'h11);
        bus(1'b1, OFF_KEY, 32'h3);
        wait_st(32'h11);
        bus(1'b1, OFF_CMD, 32'h1);
        @(posedge clk);
        chk({29'h0, wl, pl, xl}, 32'h2);
        rx_char(1'b1, 8'h41);
        wait_st(32'h11);
        chk({29'h0, wl, pl, xl}, 32'h4);
        bus(1'b1, OFF_CMD, 32'h2);
        rx_char(1'b0, 8'h02);
        rx_char(1'b0, 8'h41);
        rx_char(1'b0, 8'h03);
        rdc(OFF_STATUS, 32'h18);
        host_u.send_reply(7'h42);
        rdc(OFF_STATUS, 32'h11);
    endtask : t_run
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        rst_b = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_refuse();
        t_reply();
        t_run();
        test_done();
    end
    initial begin
        #700_000;
        miscompares++;
        test_done();
    end
endmodule : terminal_message_print_control_tb_top
`default_nettype wire
